// >>> rtl/dpdbs_ctrl.sv
`default_nettype none
module dpdbs_ctrl #(
    parameter int K_HALF = dpdbs_pkg::K_HALF,
    parameter bit SINGLE_CLK = 1'b0
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    dpdbs_if.ctl link,
    input wire logic rd_req_i,
    input wire logic [dpdbs_pkg::ADDR_W-1:0] rd_addr_i,
    output logic rd_ready_o,
    input wire logic wr_req_i,
    input wire logic [dpdbs_pkg::ADDR_W-1:0] wr_addr_i,
    input wire logic [dpdbs_pkg::BURST_W-1:0] wr_data_i,
    input wire logic [dpdbs_pkg::LANES-1:0] wr_be_i,
    output logic wr_ready_o,
    output logic [dpdbs_pkg::BURST_W-1:0] rd_data_o,
    output logic rd_valid_o
);
    // ==================================================
    // phase points of one link clock period
    localparam logic [7:0] LAST = 8'(2 * K_HALF - 1);
    localparam logic [7:0] HALF = 8'(K_HALF);
    localparam logic [7:0] MID = 8'(K_HALF / 2);
    localparam logic [7:0] LOAD = 8'(K_HALF + K_HALF / 2);
    localparam logic [7:0] SLO = 8'(K_HALF - 1);

    typedef struct packed {
        logic [7:0] ph;
        logic k;
        logic rps_n;
        logic wps_n;
        logic [1:0] bws_n;
        logic [dpdbs_pkg::ADDR_W-1:0] addr;
        logic [dpdbs_pkg::WORD_W-1:0] d;
        logic [dpdbs_pkg::ADDR_W-1:0] wa_hold;
        logic [dpdbs_pkg::WORD_W-1:0] whi;
        logic [1:0] wbe_hi;
        dpdbs_pkg::dpdbs_rd_state_t rd_st;
        logic rd_next;
        logic rd_due;
        logic [dpdbs_pkg::WORD_W-1:0] q_s1;
        logic [dpdbs_pkg::WORD_W-1:0] q_s2;
        logic [dpdbs_pkg::WORD_W-1:0] rd_lo;
        logic [dpdbs_pkg::BURST_W-1:0] rd_data;
        logic rd_valid;
    } dpdbs_ctl_t;

    dpdbs_ctl_t st;
    dpdbs_ctl_t next_st;

    // ==================================================
    // next state
    always_comb begin
        next_st = st;
        next_st.q_s1 = link.q_pin;
        next_st.q_s2 = st.q_s1;
        next_st.rd_valid = 1'b0;
        next_st.ph = (st.ph == LAST) ? 8'h00 : st.ph + 8'h01;
        next_st.k = next_st.ph < HALF;
        if (st.ph == LAST) begin
            // older read keeps its own flag so back-to-back reads overlap
            next_st.rd_due = st.rd_st == dpdbs_pkg::DPDBS_ISSUED;
            case (st.rd_st)
                dpdbs_pkg::DPDBS_ISSUED: next_st.rd_st = dpdbs_pkg::DPDBS_WAITING;
                dpdbs_pkg::DPDBS_WAITING: next_st.rd_st = dpdbs_pkg::DPDBS_IDLE;
                default: next_st.rd_st = dpdbs_pkg::DPDBS_IDLE;
            endcase
            if (st.rd_next) begin
                next_st.rd_st = dpdbs_pkg::DPDBS_ISSUED;
            end
            next_st.rd_next = 1'b0;
        end
        // pins change three sys_clk cycles ahead of the edge they serve
        if (st.ph == LOAD) begin
            next_st.rps_n = !rd_req_i;
            next_st.wps_n = !wr_req_i;
            next_st.addr = rd_addr_i;
            next_st.d = wr_data_i[dpdbs_pkg::WORD_W-1:0];
            next_st.bws_n = ~wr_be_i[1:0];
            next_st.wa_hold = wr_addr_i;
            next_st.whi = wr_data_i[dpdbs_pkg::BURST_W-1:dpdbs_pkg::WORD_W];
            next_st.wbe_hi = wr_be_i[3:2];
            next_st.rd_next = rd_req_i;
        end
        if (st.ph == MID) begin
            next_st.rps_n = 1'b1;
            next_st.wps_n = 1'b1;
            next_st.addr = st.wa_hold;
            next_st.d = st.whi;
            next_st.bws_n = ~st.wbe_hi;
        end
        if (st.rd_due && st.ph == SLO) begin
            next_st.rd_lo = st.q_s2;
        end
        if (st.rd_due && st.ph == LAST) begin
            next_st.rd_data = {st.q_s2, st.rd_lo};
            next_st.rd_valid = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            st <= '0;
            // wrap point, so the first k high after reset lasts a full half period
            st.ph <= LAST;
            st.rps_n <= 1'b1;
            st.wps_n <= 1'b1;
            st.bws_n <= 2'h3;
        end else begin
            st <= next_st;
        end
    end

    // ==================================================
    // outputs; strap high on both output clocks picks single clock mode
    assign link.k = st.k;
    assign link.k_n = !st.k;
    assign link.c = SINGLE_CLK ? 1'b1 : st.k;
    assign link.c_n = SINGLE_CLK ? 1'b1 : !st.k;
    assign link.read_port_select_n = st.rps_n;
    assign link.write_port_select_n = st.wps_n;
    assign link.byte_write_select_n = st.bws_n;
    assign link.addr = st.addr;
    assign link.wdata = st.d;
    assign rd_ready_o = st.ph == LOAD;
    assign wr_ready_o = st.ph == LOAD;
    assign rd_data_o = st.rd_data;
    assign rd_valid_o = st.rd_valid;
endmodule
`default_nettype wire

// >>> rtl/dpdbs_device.sv
// Overview of operation
// - accesses start only on positive input clock
// - write data captured on both input clocks
// - read data from output clocks or inputs
// - port and byte selects registered on inputs
// - one array, burst of two words
// - read select low latches read address
// - lower word follows next positive clock
// - higher word on negative output clock
// - outputs float after next positive output clock
// - write select low captures first word
// - first word loaded per byte selects
// - negative clock latches write address, word
// - combined 36 bits written to array
// - deselected write port ignores its inputs
// - address bus shared between both phases
// - port selects are active low
// - byte selects gate low and high bytes
// - both output clocks high selects single
// - same address read returns newest data
`default_nettype none
module dpdbs_device (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    dpdbs_if.dev link,
    output logic single_clock_mode_o,
    output logic write_busy_o
);
    // ==================================================
    // state
    typedef struct packed {
        logic [3:0] clk_s1;
        logic [3:0] clk_s2;
        logic [3:0] clk_p;
        dpdbs_pkg::dpdbs_pins_t in_s1;
        dpdbs_pkg::dpdbs_pins_t in_s2;
        logic [1:0] strap_cnt;
        logic strap_done;
        logic single;
        logic rd_pend;
        logic [dpdbs_pkg::ADDR_W-1:0] raddr;
        logic rvalid;
        logic [dpdbs_pkg::BURST_W-1:0] rbuf;
        logic hi_pend;
        logic [dpdbs_pkg::WORD_W-1:0] q;
        logic q_oe;
        logic w_act;
        logic [dpdbs_pkg::WORD_W-1:0] wlo;
        logic [1:0] wlo_be;
        logic wcommit;
        logic [dpdbs_pkg::ADDR_W-1:0] waddr;
        logic [dpdbs_pkg::BURST_W-1:0] wdata;
        logic [dpdbs_pkg::LANES-1:0] wbe;
    } dpdbs_dev_t;

    dpdbs_dev_t st;
    dpdbs_dev_t next_st;

    // link clocks rest with k and c low in dual clock mode, so only the inverted pair idles high; single clock mode ties c high
    localparam logic [3:0] CLK_IDLE = 4'((1 << dpdbs_pkg::CK_KN) | (1 << dpdbs_pkg::CK_CN));

    // ==================================================
    // helpers
    // one 18-bit half of a burst; the lower word always leaves first
    function automatic logic [dpdbs_pkg::WORD_W-1:0] burst_half(
        input logic [dpdbs_pkg::BURST_W-1:0] burst,
        input logic upper
    );
        if (upper) begin
            return burst[dpdbs_pkg::BURST_W-1:dpdbs_pkg::WORD_W];
        end
        return burst[dpdbs_pkg::WORD_W-1:0];
    endfunction

    // active-low byte selects turned into lane enables
    function automatic logic [1:0] lanes_on(input logic [1:0] sel_n);
        return ~sel_n;
    endfunction

    // ==================================================
    // array, two 18-bit halves of four 9-bit lanes
    logic [dpdbs_pkg::LANES-1:0][dpdbs_pkg::BYTE_W-1:0] mem [dpdbs_pkg::DEPTH];
    logic [dpdbs_pkg::BURST_W-1:0] mem_rd;

    assign mem_rd = mem[st.raddr];

    always_ff @(posedge sys_clk_i) begin
        if (st.wcommit) begin
            for (int i = 0; i < dpdbs_pkg::LANES; i++) begin
                if (st.wbe[i]) begin
                    mem[st.waddr][i] <= st.wdata[i*dpdbs_pkg::BYTE_W +: dpdbs_pkg::BYTE_W];
                end
            end
        end
    end

    // ==================================================
    // next state
    logic [3:0] rise;
    dpdbs_pkg::dpdbs_pins_t pin;
    logic out_r;
    logic out_nr;
    logic fetch_now;
    logic [dpdbs_pkg::BURST_W-1:0] src;

    always_comb begin
        next_st = st;
        // pins cross in two flops; edges seen on the second stage only
        next_st.clk_s1 = {link.c_n, link.c, link.k_n, link.k};
        next_st.clk_s2 = st.clk_s1;
        next_st.clk_p = st.clk_s2;
        next_st.in_s1.rps_n = link.read_port_select_n;
        next_st.in_s1.wps_n = link.write_port_select_n;
        next_st.in_s1.bws_n = link.byte_write_select_n;
        next_st.in_s1.addr = link.addr;
        next_st.in_s1.data = link.wdata;
        next_st.in_s2 = st.in_s1;
        next_st.wcommit = 1'b0;
        rise = st.clk_s2 & ~st.clk_p;
        pin = st.in_s2;

        // strap sampled once, after the synchronisers have filled
        if (!st.strap_done) begin
            if (st.strap_cnt == 2'(dpdbs_pkg::STRAP_WAIT)) begin
                next_st.single = st.clk_s2[dpdbs_pkg::CK_C] & st.clk_s2[dpdbs_pkg::CK_CN];
                next_st.strap_done = 1'b1;
            end else begin
                next_st.strap_cnt = st.strap_cnt + 2'h1;
            end
        end

        // output clocks chosen by the strap
        if (st.single) begin
            out_r = rise[dpdbs_pkg::CK_K];
            out_nr = rise[dpdbs_pkg::CK_KN];
        end else begin
            out_r = rise[dpdbs_pkg::CK_C];
            out_nr = rise[dpdbs_pkg::CK_CN];
        end

        // fetch one positive clock after the read start; the write begun on
        // the previous rise was committed half a cycle ago, so it is seen
        fetch_now = rise[dpdbs_pkg::CK_K] & st.rd_pend;
        src = fetch_now ? mem_rd : st.rbuf;

        if (rise[dpdbs_pkg::CK_K]) begin
            if (st.rd_pend) begin
                next_st.rbuf = mem_rd;
                next_st.rvalid = 1'b1;
                next_st.rd_pend = 1'b0;
            end
            if (!pin.rps_n) begin
                next_st.raddr = pin.addr;
                next_st.rd_pend = 1'b1;
            end
            // deselected write port drops data and byte selects
            next_st.w_act = !pin.wps_n;
            if (!pin.wps_n) begin
                next_st.wlo = pin.data;
                next_st.wlo_be = lanes_on(pin.bws_n);
            end
        end

        if (rise[dpdbs_pkg::CK_KN] && st.w_act) begin
            next_st.waddr = pin.addr;
            next_st.wdata = {pin.data, st.wlo};
            next_st.wbe = {lanes_on(pin.bws_n), st.wlo_be};
            next_st.wcommit = 1'b1;
            next_st.w_act = 1'b0;
        end

        if (out_r) begin
            if (fetch_now || st.rvalid) begin
                next_st.q = burst_half(src, 1'b0);
                next_st.q_oe = 1'b1;
                next_st.rbuf = src;
                next_st.rvalid = 1'b0;
                next_st.hi_pend = 1'b1;
            end else begin
                // floats right away so a neighbour bank can drive next
                next_st.q_oe = 1'b0;
            end
        end

        if (out_nr && st.hi_pend) begin
            next_st.q = burst_half(st.rbuf, 1'b1);
            next_st.hi_pend = 1'b0;
        end
    end

    // ==================================================
    // registers
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            st <= '0;
            // edge detectors start at the dual clock idle levels, so no false edge after reset except a c rise in single clock mode
            st.clk_s1 <= CLK_IDLE;
            st.clk_s2 <= CLK_IDLE;
            st.clk_p <= CLK_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ==================================================
    // outputs
    assign link.q = st.q;
    assign link.q_oe = st.q_oe;
    assign single_clock_mode_o = st.single;
    assign write_busy_o = st.w_act | st.wcommit;
endmodule
`default_nettype wire

// >>> rtl/dpdbs_if.sv
`default_nettype none
interface dpdbs_if;
    logic k;
    logic k_n;
    logic c;
    logic c_n;
    logic read_port_select_n;
    logic write_port_select_n;
    logic [1:0] byte_write_select_n;
    logic [dpdbs_pkg::ADDR_W-1:0] addr;
    logic [dpdbs_pkg::WORD_W-1:0] wdata;
    logic [dpdbs_pkg::WORD_W-1:0] q;
    logic q_oe;
    logic [dpdbs_pkg::WORD_W-1:0] q_pin;
    // ==================================================
    // floated read bus is seen as zero by the controller
    assign q_pin = q_oe ? q : '0;
    modport dev (
        input k, k_n, c, c_n, read_port_select_n, write_port_select_n,
        input byte_write_select_n, addr, wdata,
        output q, q_oe
    );
    modport ctl (
        output k, k_n, c, c_n, read_port_select_n, write_port_select_n,
        output byte_write_select_n, addr, wdata,
        input q_pin
    );
endinterface
`default_nettype wire

// >>> rtl/dpdbs_pkg.sv
`default_nettype none
package dpdbs_pkg;
    // ==================================================
    // geometry
    localparam int ADDR_W = 18;
    localparam int WORD_W = 18;
    localparam int BYTE_W = 9;
    localparam int LANES = 4;
    localparam int BURST_W = 2 * WORD_W;
    localparam int DEPTH = 2 ** ADDR_W;
    // ==================================================
    // link clock bit positions inside the sampled clock vector
    localparam int CK_K = 0;
    localparam int CK_KN = 1;
    localparam int CK_C = 2;
    localparam int CK_CN = 3;
    // ==================================================
    // timing counts in sys_clk cycles
    localparam int K_HALF = 8;
    localparam int STRAP_WAIT = 3;
    // ==================================================
    // pin bundle sampled by the memory end
    typedef struct packed {
        logic rps_n;
        logic wps_n;
        logic [1:0] bws_n;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } dpdbs_pins_t;
    // ==================================================
    // controller read state names
    typedef enum logic [1:0] {
        DPDBS_IDLE = 2'b00,
        DPDBS_ISSUED = 2'b01,
        DPDBS_WAITING = 2'b10
    } dpdbs_rd_state_t;
endpackage
`default_nettype wire

// >>> verif/dpdbs_checker.sv
`default_nettype none
module dpdbs_checker (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic k,
    input wire logic k_n,
    input wire logic c,
    input wire logic read_port_select_n,
    input wire logic write_port_select_n,
    input wire logic [1:0] byte_write_select_n,
    input wire logic [dpdbs_pkg::ADDR_W-1:0] addr,
    input wire logic [dpdbs_pkg::WORD_W-1:0] wdata,
    input wire logic q_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // ==================================================
    // link phases
    sequence k_edge;
        $rose(k);
    endsequence
    sequence rd_start;
        $rose(k) && !read_port_select_n;
    endsequence
    sequence rd_idle;
        $rose(k) && read_port_select_n;
    endsequence
    // ==================================================
    // controller side of the link
    k_high_a: assert property (k_edge |-> k [*8] ##1 !k)
        else $error("k high time wrong");
    rd_setup_a: assert property ($fell(read_port_select_n) |-> ##[1:6] $rose(k))
        else $error("read select not followed by k rise");
    wr_setup_a: assert property ($fell(write_port_select_n) |-> ##[1:6] $rose(k))
        else $error("write select not followed by k rise");
    // settling margin both sides of the edge, the device samples late
    port_hold_a: assert property (k_edge |-> ($stable(read_port_select_n) &&
        $stable(write_port_select_n) && $stable(addr) && $stable(wdata)) [*3])
        else $error("inputs move near k rise");
    wr_hold_a: assert property ($rose(k_n) |-> ($stable(addr) && $stable(wdata) &&
        $stable(byte_write_select_n)) [*3])
        else $error("write inputs move near k_n rise");
    // ==================================================
    // device side of the link
    rd_answer_a: assert property (rd_start |-> ##[16:24] q_oe)
        else $error("read data never driven");
    rd_float_a: assert property (rd_idle |-> ##[16:24] !q_oe)
        else $error("read bus not floated");
    oe_clock_a: assert property ($rose(q_oe) |-> c && $past(c, 2))
        else $error("read data not launched by output clock");
    burst_span_a: assert property ($rose(q_oe) |-> q_oe [*8])
        else $error("burst cut short");
endmodule
`default_nettype wire

// >>> verif/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic rd_req_i = 1'b0;
    logic wr_req_i = 1'b0;
    logic [dpdbs_pkg::ADDR_W-1:0] rd_addr_i = '0;
    logic [dpdbs_pkg::ADDR_W-1:0] wr_addr_i = '0;
    logic [dpdbs_pkg::BURST_W-1:0] wr_data_i = '0;
    logic [dpdbs_pkg::LANES-1:0] wr_be_i = '0;
    logic [dpdbs_pkg::BURST_W-1:0] rd_data;
    logic rd_ready, wr_ready, rd_valid, single_clk, wr_busy;
    logic [35:0] shadow [int];
    int fails = 0;
    int compares = 0;
    dpdbs_if link ();
    dpdbs_device i_dpdbs_device (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .link(link),
        .single_clock_mode_o(single_clk), .write_busy_o(wr_busy));
    dpdbs_ctrl i_dpdbs_ctrl (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .link(link),
        .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i), .rd_ready_o(rd_ready),
        .wr_req_i(wr_req_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .wr_be_i(wr_be_i),
        .wr_ready_o(wr_ready), .rd_data_o(rd_data), .rd_valid_o(rd_valid));
    dpdbs_checker i_dpdbs_checker (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .k(link.k),
        .k_n(link.k_n), .c(link.c), .read_port_select_n(link.read_port_select_n),
        .write_port_select_n(link.write_port_select_n),
        .byte_write_select_n(link.byte_write_select_n), .addr(link.addr), .wdata(link.wdata),
        .q_oe(link.q_oe));
    // ==================================================
    // helpers
    initial forever #5 sys_clk_i = ~sys_clk_i;
    task automatic chk36(input logic [35:0] got, input logic [35:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk36({35'h0, got}, {35'h0, exp});
    endtask
    // bounded wait, sampled mid-cycle so values have settled
    task automatic wait_hi(ref logic s, input int lim);
        for (int n = 0; n < lim && s !== 1'b1; n++)
            @(negedge sys_clk_i);
    endtask
    task automatic wr(input logic [17:0] a, input logic [35:0] d, input logic [3:0] be);
        @(posedge sys_clk_i);
        wr_addr_i <= a;
        wr_data_i <= d;
        wr_be_i <= be;
        wr_req_i <= 1'b1;
        @(negedge sys_clk_i);
        wait_hi(wr_ready, 40);
        @(posedge sys_clk_i);
        wr_req_i <= 1'b0;
        for (int i = 0; i < 4; i++)
            if (be[i])
                shadow[a][i*9 +: 9] = d[i*9 +: 9];
    endtask
    task automatic rd_issue(input logic [17:0] a);
        @(posedge sys_clk_i);
        rd_addr_i <= a;
        rd_req_i <= 1'b1;
        @(negedge sys_clk_i);
        wait_hi(rd_ready, 40);
        @(posedge sys_clk_i);
        rd_req_i <= 1'b0;
    endtask
    task automatic rd_wait(input logic [35:0] exp);
        @(negedge sys_clk_i);
        wait_hi(rd_valid, 60);
        chk1(rd_valid, 1'b1);
        chk36(rd_data, exp);
    endtask
    // ==================================================
    // scenarios
    task automatic t_edges();
        wr(18'h00000, 36'h123456789, 4'hf);
        wait_hi(wr_busy, 20);
        chk1(wr_busy, 1'b1);
        wr(18'h3ffff, 36'hfedcba987, 4'hf);
        rd_issue(18'h3ffff);
        for (int n = 0; n < 40 && link.q_oe !== 1'b1; n++)
            @(negedge sys_clk_i);
        chk36({18'h0, link.q_pin}, 36'h00003a987);
        for (int n = 0; n < 20 && link.q_pin === 18'h3a987; n++)
            @(negedge sys_clk_i);
        chk36({18'h0, link.q_pin}, 36'h00003fb72);
        rd_wait(shadow[18'h3ffff]);
        rd_issue(18'h00000);
        rd_wait(shadow[18'h00000]);
    endtask
    task automatic t_lanes();
        logic [3:0] bes [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'h6, 4'h9};
        wr(18'h00155, 36'h5a5a5a5a5, 4'hf);
        for (int i = 0; i < 7; i++) begin
            wr(18'h00155, {9{4'(i + 1)}}, bes[i]);
            rd_issue(18'h00155);
            rd_wait(shadow[18'h00155]);
        end
    endtask
    task automatic t_forward();
        fork
            wr(18'h00000, 36'h0f0f0f0f0, 4'hf);
            rd_issue(18'h00000);
        join
        rd_wait(36'h0f0f0f0f0);
    endtask
    task automatic t_b2b_float();
        // write inputs shown with the write port deselected must not land
        @(posedge sys_clk_i);
        wr_addr_i <= 18'h00155;
        wr_data_i <= 36'h0deadbeef;
        wr_be_i <= 4'hf;
        repeat (40) @(posedge sys_clk_i);
        rd_issue(18'h00155);
        rd_issue(18'h3ffff);
        rd_wait(shadow[18'h00155]);
        rd_wait(shadow[18'h3ffff]);
        repeat (40) @(negedge sys_clk_i);
        chk1(link.q_oe, 1'b0);
        chk36({18'h0, link.q_pin}, 36'h0);
    endtask
    task automatic summarize();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ==================================================
    // main sequence and watchdog
    initial begin
        repeat (3) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        repeat (20) @(posedge sys_clk_i);
        chk1(single_clk, 1'b0);
        t_edges();
        t_lanes();
        t_forward();
        t_b2b_float();
        summarize();
    end
    // whole run needs about 10 us
    initial begin
        #100us;
        fails++;
        summarize();
    end
endmodule
`default_nettype wire
